// ### logic/pcri_top.sv
/*
 Card side command handler for the add-to-cyclic-record command,
 PIN verification with retry query, and PIN replacement, all
 driven from APB registers.
 Assumes an APB master, and a separate power-on reset (nv_rstn)
 that models first personalisation of the nonvolatile PIN state.
*/
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "pcri_defs.svh"
// Functional notes
// - Add command sums value with newest record, writes sum into oldest record.
// - After a good add, the written record becomes record 1.
// - Add allowed only if access rule holds tag 84 with code 32.
// - Add refused, records unchanged, when sum exceeds all-FF maximum.
// - P1 zero selects current file; 100xxxxx carries short file id.
// - Add length must be 1..127; record length at most 127.
// - Add response is new record followed by added value bytes.
// - Verified state is shared by all logical channels.
// - PIN compared only when neither disabled nor blocked.
// - PIN-guarded file needs prior verification unless PIN disabled.
// - Matching PIN restores attempt counter to 3.
// - Wrong PIN decrements counter, answers 63C2 then 63C1.
// - Third wrong PIN blocks it, answers 63C0, access stays denied.
// - Verification with data on a blocked PIN answers 6983.
// - Empty verification returns retries as 63CX, even disabled or blocked.
// - Empty verification on blocked PIN answers 63C0 or 6983.
// - P2 holds scope bit, zero bits 6-5, reference; Lc empty or 08.
// - Changed PIN is used at once on every channel.
// - Replacement needs old and new PIN; PIN not disabled nor blocked.
// - Old PIN matching resets counter to 3 and adopts new PIN.
// - Old PIN wrong decrements counter, keeps PIN, blocks after three.
// - Replacement needs P1 zero and Lc 10: old then new PIN.
module pcri_top #(
  parameter int          NREC        = 4,
  parameter logic [7:0]  INS_VERIFY  = 8'h20,
  parameter logic [7:0]  INS_CHANGE  = 8'h24,
  parameter logic [63:0] PIN_DEFAULT = 64'h3030303030303030
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    nv_rstn,
  input  wire pcri_pkg::pcri_apb_req_t apb_req,
  output      pcri_pkg::pcri_apb_rsp_t apb_rsp
);
  import pcri_pkg::*;
  localparam int SLOT_W = (NREC > 1) ? $clog2(NREC) : 1;
  localparam int REC_AW = SLOT_W + `PCRI_BYTE_AW;
  localparam int BYTES  = 1 << `PCRI_BYTE_AW;
  // ========================================================
  // Storage
  logic [7:0] din_mem [BYTES];
  logic [7:0] tmp_mem [BYTES];
  logic [7:0] rec_mem [NREC * BYTES];
  // Volatile state
  pcri_cmd_t             cmd_reg,     cmd_next;
  pcri_fcfg_t            fcfg_reg,    fcfg_next;
  logic [7:0]            pdis_reg,    pdis_next;
  logic [7:0]            rlen_reg,    rlen_next;
  logic [SLOT_W-1:0]     newest_reg,  newest_next;
  logic [6:0]            din_idx_reg, din_idx_next;
  logic [7:0]            resp_idx_reg, resp_idx_next;
  logic [7:0]            resp_len_reg, resp_len_next;
  logic [15:0]           sw_reg,      sw_next;
  pcri_state_t           state_reg,   state_next;
  logic [6:0]            i_reg,       i_next;
  logic                  carry_reg,   carry_next;
  logic [7:0]            ver_reg,     ver_next;
  logic [31:0]           prdata_reg,  prdata_next;
  // Nonvolatile state
  logic [`PCRI_NPIN-1:0][1:0]  cnt_reg,  cnt_next;
  logic [`PCRI_NPIN-1:0]       blk_reg,  blk_next;
  logic [`PCRI_NPIN-1:0][63:0] pin_reg,  pin_next;
  // Memory write controls
  logic                  din_we;
  logic                  tmp_we;
  logic [7:0]            tmp_wd;
  logic                  rec_we;
  logic [REC_AW-1:0]     rec_wa;
  logic [7:0]            rec_wd;
  // Decode helpers
  logic                  setup;
  logic                  acc;
  logic                  wr;
  logic                  mapped;
  logic                  start;
  pcri_p1_t              p1v;
  pcri_p2_t              p2v;
  logic [2:0]            pidx;
  logic                  file_ok;
  logic [SLOT_W-1:0]     oldest;
  logic [7:0]            off;
  logic [7:0]            bidx;
  logic [7:0]            addend;
  logic [7:0]            cur_byte;
  logic [8:0]            sum;
  logic [1:0]            cnt_dec;
  logic [7:0]            resp_byte;
  pcri_stat_t            stat;
  // Eight PIN bytes from the command buffer, first byte on top
  function automatic logic [63:0] pin_at(input logic [6:0] base);
    logic [63:0] v;
    v = '0;
    for (int k = 0; k < `PCRI_PIN_BYTES; k++) begin
      v = {v[55:0], din_mem[base + 7'(k)]};
    end
    return v;
  endfunction
  // ========================================================
  // Bus decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc   = apb_req.psel & apb_req.penable;
  assign wr    = acc & apb_req.pwrite;
  assign start = wr && (apb_req.paddr == `PCRI_OFF_CTRL)
                 && apb_req.pwdata[`PCRI_CTRL_GO]
                 && (state_reg == PCRI_IDLE);
  always_comb begin
    case (apb_req.paddr)
      `PCRI_OFF_CMD, `PCRI_OFF_CTRL, `PCRI_OFF_STAT,
      `PCRI_OFF_DIN, `PCRI_OFF_RESP, `PCRI_OFF_FCFG,
      `PCRI_OFF_PDIS, `PCRI_OFF_PSTA, `PCRI_OFF_RLEN,
      `PCRI_OFF_RWR, `PCRI_OFF_NEWEST: mapped = 1'b1;
      default:                         mapped = 1'b0;
    endcase
  end
  // Zero-wait answer, error on unmapped offsets
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc & ~mapped;
  assign apb_rsp.prdata  = prdata_reg;
  // ========================================================
  // Command field views and datapath helpers
  assign p1v      = pcri_p1_t'(cmd_reg.p1);
  assign p2v      = pcri_p2_t'(cmd_reg.p2);
  assign pidx     = {p2v.specific, p2v.num[1:0]};
  assign oldest   = (newest_reg == SLOT_W'(NREC - 1)) ? '0
                    : newest_reg + SLOT_W'(1);
  assign off      = rlen_reg - cmd_reg.lc;
  assign bidx     = {1'b0, i_reg} - off;
  assign cur_byte = rec_mem[{newest_reg, i_reg}];
  assign addend   = ({1'b0, i_reg} >= off) ? din_mem[bidx[6:0]]
                    : 8'h00;
  assign sum      = {1'b0, cur_byte} + {1'b0, addend}
                    + {8'h00, carry_reg};
  assign cnt_dec  = cnt_reg[pidx] - 2'h1;
  // PIN-guarded file open when disabled or verified and unblocked
  assign file_ok = ~fcfg_reg.pin_req
                   | pdis_reg[fcfg_reg.pin_idx]
                   | (ver_reg[fcfg_reg.pin_idx]
                      & ~blk_reg[fcfg_reg.pin_idx]);
  // New record then the added bytes
  always_comb begin
    if (resp_idx_reg >= resp_len_reg) begin
      resp_byte = 8'h00;
    end else if (resp_idx_reg < rlen_reg) begin
      resp_byte = tmp_mem[resp_idx_reg[6:0]];
    end else begin
      resp_byte = din_mem[7'(resp_idx_reg - rlen_reg)];
    end
  end
  always_comb begin
    stat          = '0;
    stat.resp_len = resp_len_reg;
    stat.busy     = (state_reg != PCRI_IDLE);
    stat.sw       = sw_reg;
  end
  // ========================================================
  // Register, command and sequencer next state
  always_comb begin
    cmd_next      = cmd_reg;
    fcfg_next     = fcfg_reg;
    pdis_next     = pdis_reg;
    rlen_next     = rlen_reg;
    newest_next   = newest_reg;
    din_idx_next  = din_idx_reg;
    resp_idx_next = resp_idx_reg;
    resp_len_next = resp_len_reg;
    sw_next       = sw_reg;
    state_next    = state_reg;
    i_next        = i_reg;
    carry_next    = carry_reg;
    ver_next      = ver_reg;
    prdata_next   = prdata_reg;
    cnt_next      = cnt_reg;
    blk_next      = blk_reg;
    pin_next      = pin_reg;
    din_we        = 1'b0;
    tmp_we        = 1'b0;
    tmp_wd        = sum[7:0];
    rec_we        = 1'b0;
    rec_wa        = '0;
    rec_wd        = 8'h00;
    // Read data captured in the setup cycle
    if (setup && !apb_req.pwrite) begin
      case (apb_req.paddr)
        `PCRI_OFF_CMD:    prdata_next = cmd_reg;
        `PCRI_OFF_STAT:   prdata_next = stat;
        `PCRI_OFF_RESP:   prdata_next = {24'h000000, resp_byte};
        `PCRI_OFF_FCFG:   prdata_next = fcfg_reg;
        `PCRI_OFF_PDIS:   prdata_next = {24'h000000, pdis_reg};
        `PCRI_OFF_PSTA:   prdata_next = {cnt_reg, blk_reg, ver_reg};
        `PCRI_OFF_RLEN:   prdata_next = {24'h000000, rlen_reg};
        `PCRI_OFF_NEWEST: prdata_next = 32'(newest_reg);
        default:          prdata_next = 32'h00000000;
      endcase
    end
    // Response bytes pop on completed reads
    if (acc && !apb_req.pwrite && apb_req.paddr == `PCRI_OFF_RESP
        && resp_idx_reg < resp_len_reg) begin
      resp_idx_next = resp_idx_reg + 8'h01;
    end
    // Register writes; command buffer frozen while busy
    if (wr) begin
      case (apb_req.paddr)
        `PCRI_OFF_CMD: begin
          if (state_reg == PCRI_IDLE) begin
            cmd_next     = pcri_cmd_t'(apb_req.pwdata);
            din_idx_next = '0;
          end
        end
        `PCRI_OFF_DIN: begin
          if (state_reg == PCRI_IDLE) begin
            din_we       = 1'b1;
            din_idx_next = din_idx_reg + 7'h01;
          end
        end
        `PCRI_OFF_FCFG:   fcfg_next = pcri_fcfg_t'(apb_req.pwdata);
        `PCRI_OFF_PDIS:   pdis_next = apb_req.pwdata[7:0];
        `PCRI_OFF_RLEN:   rlen_next = apb_req.pwdata[7:0];
        `PCRI_OFF_NEWEST: newest_next = apb_req.pwdata[SLOT_W-1:0];
        `PCRI_OFF_RWR: begin
          if (state_reg == PCRI_IDLE) begin
            rec_we = 1'b1;
            rec_wa = apb_req.pwdata[`PCRI_RWR_ALSB +: REC_AW];
            rec_wd = apb_req.pwdata[`PCRI_RWR_DMSB:`PCRI_RWR_DLSB];
          end
        end
        default: ;
      endcase
    end
    case (state_reg)
      PCRI_IDLE: begin
        if (start) begin
          resp_idx_next = '0;
          resp_len_next = '0;
          if (cmd_reg.ins == `PCRI_INS_INCR) begin
            if (!(cmd_reg.p1 == 8'h00 || p1v.mode == `PCRI_P1_SFI)
                || cmd_reg.p2 != 8'h00) begin
              sw_next = `PCRI_SW_P1P2;
            end else if (cmd_reg.p1 != 8'h00
                         && p1v.short_file_id != fcfg_reg.short_file_id) begin
              sw_next = `PCRI_SW_NOFILE;
            end else if (!fcfg_reg.cyclic) begin
              sw_next = `PCRI_SW_NOTCYC;
            end else if (cmd_reg.lc == 8'h00
                         || cmd_reg.lc >= `PCRI_LC_MAX
                         || rlen_reg == 8'h00
                         || rlen_reg > `PCRI_REC_MAX
                         || cmd_reg.lc > rlen_reg) begin
              sw_next = `PCRI_SW_LEN;
            end else if (fcfg_reg.am_tag != `PCRI_AM_TAG
                         || fcfg_reg.am_ins != `PCRI_INS_INCR
                         || !file_ok) begin
              sw_next = `PCRI_SW_SEC;
            end else begin
              state_next = PCRI_ADD;
              i_next     = 7'(rlen_reg - 8'h01);
              carry_next = 1'b0;
            end
          end else if (cmd_reg.ins == INS_VERIFY
                       || cmd_reg.ins == INS_CHANGE) begin
            if (cmd_reg.p1 != 8'h00 || p2v.rfu != 2'b00) begin
              sw_next = `PCRI_SW_P1P2;
            end else if (cmd_reg.ins == INS_VERIFY
                         && cmd_reg.lc == 8'h00) begin
              // Blocked counter is zero, so 63C0 comes out
              sw_next = {`PCRI_SW_RETRY, 2'b00, cnt_reg[pidx]};
            end else if ((cmd_reg.ins == INS_VERIFY
                          && cmd_reg.lc != `PCRI_VFY_LC)
                         || (cmd_reg.ins == INS_CHANGE
                          && cmd_reg.lc != `PCRI_CHG_LC)) begin
              sw_next = `PCRI_SW_LEN;
            end else if (blk_reg[pidx]) begin
              sw_next = `PCRI_SW_BLOCKED;
            end else if (pdis_reg[pidx]) begin
              sw_next = `PCRI_SW_NOCOND;
            end else if (pin_at('0) == pin_reg[pidx]) begin
              cnt_next[pidx] = `PCRI_TRIES;
              ver_next[pidx] = 1'b1;
              sw_next        = `PCRI_SW_OK;
              if (cmd_reg.ins == INS_CHANGE) begin
                pin_next[pidx] = pin_at(`PCRI_NEW_BASE);
              end
            end else begin
              // Wrong PIN on any channel costs one attempt
              cnt_next[pidx] = cnt_dec;
              ver_next[pidx] = 1'b0;
              sw_next = {`PCRI_SW_RETRY, 2'b00, cnt_dec};
              if (cnt_dec == 2'h0) begin
                blk_next[pidx] = 1'b1;
              end
            end
          end else begin
            sw_next = `PCRI_SW_INS;
          end
        end
      end
      PCRI_ADD: begin
        // One byte per cycle, least significant first
        tmp_we     = 1'b1;
        carry_next = sum[8];
        i_next     = i_reg - 7'h01;
        if (i_reg == 7'h00) begin
          if (sum[8]) begin
            sw_next    = `PCRI_SW_OVF;
            state_next = PCRI_IDLE;
          end else begin
            state_next = PCRI_COMMIT;
            i_next     = '0;
          end
        end
      end
      PCRI_COMMIT: begin
        // Copy the sum into the oldest record
        rec_we = 1'b1;
        rec_wa = {oldest, i_reg};
        rec_wd = tmp_mem[i_reg];
        i_next = i_reg + 7'h01;
        if ({1'b0, i_reg} == rlen_reg - 8'h01) begin
          newest_next   = oldest;
          sw_next       = `PCRI_SW_OK;
          resp_len_next = rlen_reg + cmd_reg.lc;
          state_next    = PCRI_IDLE;
        end
      end
      default: state_next = PCRI_IDLE;
    endcase
  end
  // ========================================================
  // Volatile registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg      <= '0;
      fcfg_reg     <= '0;
      pdis_reg     <= 8'h00;
      rlen_reg     <= 8'h00;
      newest_reg   <= '0;
      din_idx_reg  <= '0;
      resp_idx_reg <= 8'h00;
      resp_len_reg <= 8'h00;
      sw_reg       <= `PCRI_SW_OK;
      state_reg    <= PCRI_IDLE;
      i_reg        <= '0;
      carry_reg    <= 1'b0;
      ver_reg      <= 8'h00;
      prdata_reg   <= 32'h00000000;
    end else begin
      cmd_reg      <= cmd_next;
      fcfg_reg     <= fcfg_next;
      pdis_reg     <= pdis_next;
      rlen_reg     <= rlen_next;
      newest_reg   <= newest_next;
      din_idx_reg  <= din_idx_next;
      resp_idx_reg <= resp_idx_next;
      resp_len_reg <= resp_len_next;
      sw_reg       <= sw_next;
      state_reg    <= state_next;
      i_reg        <= i_next;
      carry_reg    <= carry_next;
      ver_reg      <= ver_next;
      prdata_reg   <= prdata_next;
    end
  end
  // Nonvolatile PIN state, untouched by card resets
  always_ff @(posedge pclk or negedge nv_rstn) begin
    if (!nv_rstn) begin
      cnt_reg <= {`PCRI_NPIN{`PCRI_TRIES}};
      blk_reg <= '0;
      pin_reg <= {`PCRI_NPIN{PIN_DEFAULT}};
    end else begin
      cnt_reg <= cnt_next;
      blk_reg <= blk_next;
      pin_reg <= pin_next;
    end
  end
  // Byte memories
  always_ff @(posedge pclk) begin
    if (din_we) begin
      din_mem[din_idx_reg] <= apb_req.pwdata[7:0];
    end
    if (tmp_we) begin
      tmp_mem[i_reg] <= tmp_wd;
    end
    if (rec_we) begin
      rec_mem[rec_wa] <= rec_wd;
    end
  end
endmodule

// ### logic/pcri_defs.svh
/*
 Constants of the card command handler: register offsets, status
 words, command codes, limits and bit positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PCRI_DEFS_SVH
`define PCRI_DEFS_SVH

// ==========================================================
// Register byte offsets
`define PCRI_OFF_CMD    8'h00
`define PCRI_OFF_CTRL   8'h04
`define PCRI_OFF_STAT   8'h08
`define PCRI_OFF_DIN    8'h0C
`define PCRI_OFF_RESP   8'h10
`define PCRI_OFF_FCFG   8'h14
`define PCRI_OFF_PDIS   8'h18
`define PCRI_OFF_PSTA   8'h1C
`define PCRI_OFF_RLEN   8'h20
`define PCRI_OFF_RWR    8'h24
`define PCRI_OFF_NEWEST 8'h28

// ==========================================================
// Field positions
`define PCRI_CTRL_GO    0
`define PCRI_RWR_DLSB   0
`define PCRI_RWR_DMSB   7
`define PCRI_RWR_ALSB   16

// ==========================================================
// Command codes and access rule coding
`define PCRI_INS_INCR   8'h32
`define PCRI_AM_TAG     8'h84
`define PCRI_P1_SFI     3'b100

// ==========================================================
// Status words
`define PCRI_SW_OK      16'h9000
`define PCRI_SW_RETRY   12'h63C
`define PCRI_SW_BLOCKED 16'h6983
`define PCRI_SW_NOCOND  16'h6985
`define PCRI_SW_SEC     16'h6982
`define PCRI_SW_P1P2    16'h6A86
`define PCRI_SW_LEN     16'h6700
`define PCRI_SW_NOFILE  16'h6A82
`define PCRI_SW_NOTCYC  16'h6981
`define PCRI_SW_OVF     16'h6A84
`define PCRI_SW_INS     16'h6D00

// ==========================================================
// Limits and initial values
`define PCRI_TRIES      2'h3
`define PCRI_VFY_LC     8'h08
`define PCRI_CHG_LC     8'h10
`define PCRI_LC_MAX     8'h80
`define PCRI_REC_MAX    8'h7F
`define PCRI_PIN_BYTES  8
`define PCRI_NEW_BASE   7'h08
`define PCRI_NPIN       8
`define PCRI_BYTE_AW    7

`endif

// ### logic/pcri_pkg.sv
/*
 Types of the card command handler: bus carriers, register views
 and the sequencer states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pcri_pkg;

  // ========================================================
  // APB carriers
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } pcri_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pcri_apb_rsp_t;

  // ========================================================
  // Register views
  typedef struct packed {
    logic [7:0] lc;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [7:0] ins;
  } pcri_cmd_t;

  typedef struct packed {
    logic [1:0] spare_hi;
    logic       cyclic;
    logic [4:0] short_file_id;
    logic [3:0] spare_lo;
    logic       pin_req;
    logic [2:0] pin_idx;
    logic [7:0] am_ins;
    logic [7:0] am_tag;
  } pcri_fcfg_t;

  typedef struct packed {
    logic [7:0]  resp_len;
    logic [6:0]  spare;
    logic        busy;
    logic [15:0] sw;
  } pcri_stat_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [4:0] short_file_id;
  } pcri_p1_t;

  typedef struct packed {
    logic       specific;
    logic [1:0] rfu;
    logic [4:0] num;
  } pcri_p2_t;

  typedef enum logic [1:0] {
    PCRI_IDLE,
    PCRI_ADD,
    PCRI_COMMIT
  } pcri_state_t;

endpackage

// ### bench/pcri_top_monitor.sv
/* Checker of the bus answers of pcri_top.
 Assumes bind into pcri_top; sees its ports only. */
`timescale 1ns/1ns
`include "pcri_defs.svh"
module pcri_mon #(
  parameter logic [7:0] INS_VERIFY = 8'h20,
  parameter logic [7:0] INS_CHANGE = 8'h24
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    nv_rstn,
  input wire pcri_pkg::pcri_apb_req_t apb_req,
  input wire pcri_pkg::pcri_apb_rsp_t apb_rsp
);
  import pcri_pkg::*;
  pcri_cmd_t   cmd_reg;
  logic [7:0]  blk_reg;
  logic        done_reg, blkgo_reg;
  logic        acc, stat, psta, pinok, ver, chg;
  wire  [31:0] rd = apb_rsp.prdata;
  wire  [15:0] sw = apb_rsp.prdata[15:0];
  // Settled status reads after a go, and state reads
  assign acc   = apb_req.psel & apb_req.penable;
  assign stat  = acc & !apb_req.pwrite & apb_req.paddr == `PCRI_OFF_STAT
                 & !rd[16] & done_reg;
  assign psta  = acc & !apb_req.pwrite & apb_req.paddr == `PCRI_OFF_PSTA;
  assign pinok = cmd_reg.p1 == 8'h00 && cmd_reg.p2[6:5] == 2'h0;
  assign ver   = cmd_reg.ins == INS_VERIFY;
  assign chg   = cmd_reg.ins == INS_CHANGE;
  // Last command and blocked state of its PIN at the go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg   <= '0;
      done_reg  <= 1'b0;
      blkgo_reg <= 1'b0;
    end else if (acc & apb_req.pwrite) begin
      if (apb_req.paddr == `PCRI_OFF_CMD) begin
        cmd_reg  <= apb_req.pwdata;
        done_reg <= 1'b0;
      end
      if (apb_req.paddr == `PCRI_OFF_CTRL && apb_req.pwdata[0]) begin
        done_reg  <= 1'b1;
        blkgo_reg <= blk_reg[{cmd_reg.p2[7], cmd_reg.p2[1:0]}];
      end
    end
  end
  // Blocked flags seen so far; blocking is never undone here
  always_ff @(posedge pclk or negedge nv_rstn) begin
    if (!nv_rstn) blk_reg <= '0;
    else if (psta) blk_reg <= blk_reg | rd[15:8];
  end
  // ========================================================
  // Assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_blk_data; stat & ver & pinok & cmd_reg.lc == 8'h08 & blkgo_reg
    |-> sw == `PCRI_SW_BLOCKED; endproperty
  a_blk_data: assert property (p_blk_data)
    else $error("blocked verify status");
  property p_blk_empty; stat & ver & pinok & cmd_reg.lc == 8'h00 & blkgo_reg
    |-> sw == 16'h63C0; endproperty
  a_blk_empty: assert property (p_blk_empty)
    else $error("blocked retry query status");
  property p_rfu; stat & (ver | chg) & cmd_reg.p2[6:5] != 2'h0
    |-> sw == `PCRI_SW_P1P2; endproperty
  a_rfu: assert property (p_rfu)
    else $error("reserved P2 bits accepted");
  property p_chg_len; stat & chg & pinok & cmd_reg.lc != `PCRI_CHG_LC
    |-> sw == `PCRI_SW_LEN; endproperty
  a_chg_len: assert property (p_chg_len)
    else $error("change length accepted");
  property p_add_p1; stat & cmd_reg.ins == `PCRI_INS_INCR & cmd_reg.p1 != 8'h00
    & cmd_reg.p1[7:5] != `PCRI_P1_SFI |-> sw == `PCRI_SW_P1P2; endproperty
  a_add_p1: assert property (p_add_p1)
    else $error("reserved P1 of add accepted");
  property p_fail; stat & ver & pinok & cmd_reg.lc == 8'h08 & !blkgo_reg
    & sw[15:4] == `PCRI_SW_RETRY |-> sw[3:0] < 4'h3; endproperty
  a_fail: assert property (p_fail)
    else $error("failed verify shows full count");
  property p_cnt; psta |-> rd[13] == (rd[27:26] == 2'h0); endproperty
  a_cnt: assert property (p_cnt)
    else $error("blocked flag and counter disagree");
  property p_vb; psta |-> (rd[7:0] & rd[15:8]) == 8'h00; endproperty
  a_vb: assert property (p_vb)
    else $error("blocked PIN shown verified");
endmodule
bind pcri_top pcri_mon #(.INS_VERIFY(INS_VERIFY), .INS_CHANGE(INS_CHANGE))
  pcri_mon_i (.pclk(pclk), .presetn(presetn), .nv_rstn(nv_rstn),
  .apb_req(apb_req), .apb_rsp(apb_rsp));

// ### bench/pcri_term.sv
/* Terminal model: APB master that sends card commands.
 Assumes a slave that raises pready in the access phase. */
`timescale 1ns/1ns
`include "pcri_defs.svh"
module pcri_term (
  input  wire logic                    pclk,
  output pcri_pkg::pcri_apb_req_t      apb_req,
  input  wire pcri_pkg::pcri_apb_rsp_t apb_rsp
);
  import pcri_pkg::*;
  initial apb_req = '0;
  // ========================================================
  // One transfer: setup, access until pready, release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    apb_req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '{~a, 1'b0, 1'b0, w, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask
  // Command header, exactly Lc bytes first byte first, go, poll
  task automatic cmd(input logic [31:0] hdr, input logic [127:0] d,
                     input logic [7:0] n, output logic [31:0] st);
    wr(`PCRI_OFF_CMD, hdr);
    for (int i = 0; i < n; i++) begin
      wr(`PCRI_OFF_DIN, {24'h0, d[127-8*i-:8]});
    end
    wr(`PCRI_OFF_CTRL, 32'h1);
    do rd(`PCRI_OFF_STAT, st); while (st[16] !== 1'b0);
  endtask
endmodule

// ### bench/tb_top.sv
/* Bench of pcri_top: PIN, retry, change and add scenarios.
 Assumes pcri_term as terminal and the bound pcri_mon. */
`timescale 1ns/1ns
`include "pcri_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
  import pcri_pkg::*;
  localparam logic [7:0]   V  = 8'h20;
  localparam logic [7:0]   C  = 8'h24;
  localparam logic [63:0]  PG = 64'h3030303030303030;
  localparam logic [63:0]  PB = 64'h3131313131313131;
  localparam logic [63:0]  PN = 64'h3232323232323232;
  localparam logic [127:0] WG = {PG, 64'h0};
  localparam logic [127:0] WB = {PB, 64'h0};
  localparam logic [23:0]  RS = 24'h010705;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          nv_rstn = 1'b0;
  pcri_apb_req_t req;
  pcri_apb_rsp_t rsp;
  logic [31:0]   st, q;
  logic          e;
  int            err_total = 0;
  int            tests_run = 0;
  int            cyc = 0;
  // Clock and a bound on run length
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  pcri_top pcri_top_i (.pclk(pclk), .presetn(presetn), .nv_rstn(nv_rstn),
    .apb_req(req), .apb_rsp(rsp));
  pcri_term pcri_term_i (.pclk(pclk), .apb_req(req), .apb_rsp(rsp));
  // ========================================================
  // Shared steps
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    pcri_term_i.wr(a, d);
  endtask
  task automatic pchk(input logic [7:0] ins, p2, lc, input logic [127:0] d,
                      input logic [15:0] x);
    pcri_term_i.cmd({lc, p2, 8'h00, ins}, d, lc, st);
    `CHK(st[15:0], x)
  endtask
  task automatic add(input logic [7:0] p1, lc, input logic [15:0] x);
    pcri_term_i.cmd({lc, 8'h00, p1, `PCRI_INS_INCR}, {8'h01, 120'h0}, lc, st);
    `CHK(st[15:0], x)
  endtask
  // Scenarios
  task automatic t_pins();
    pcri_term_i.rd(`PCRI_OFF_PSTA, q);
    `CHK(q, 32'hFFFF_0000)
    pcri_term_i.xfer(1'b0, 8'h2C, 32'h0, q, e);
    `CHK({e, q}, 33'h1_0000_0000)
    pchk(V, 8'h80, 8'h08, WB, 16'h63C2);
    pchk(V, 8'h80, 8'h08, WG, 16'h9000);
    pchk(V, 8'h80, 8'h00, '0, 16'h63C3);
    pcri_term_i.rd(`PCRI_OFF_PSTA, q);
    `CHK(q[4], 1'b1)
    pchk(V, 8'hA2, 8'h08, WG, 16'h6A86);
  endtask
  task automatic t_retry();
    pchk(V, 8'h81, 8'h08, WB, 16'h63C2);
    pchk(V, 8'h81, 8'h08, WB, 16'h63C1);
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pchk(V, 8'h81, 8'h00, '0, 16'h63C1);
    pchk(V, 8'h81, 8'h08, WB, 16'h63C0);
    pcri_term_i.rd(`PCRI_OFF_PSTA, q);
    `CHK(q[13], 1'b1)
    pchk(V, 8'h81, 8'h08, WG, 16'h6983);
    pchk(V, 8'h81, 8'h00, '0, 16'h63C0);
  endtask
  task automatic t_change();
    pchk(C, 8'h82, 8'h10, {PB, PN}, 16'h63C2);
    pchk(V, 8'h82, 8'h08, WG, 16'h9000);
    pchk(C, 8'h82, 8'h10, {PG, PN}, 16'h9000);
    pchk(V, 8'h82, 8'h08, {PN, 64'h0}, 16'h9000);
    pchk(V, 8'h82, 8'h00, '0, 16'h63C3);
    pchk(C, 8'h82, 8'h08, WG, 16'h6700);
    w(`PCRI_OFF_PDIS, 32'h02);
    pchk(V, 8'h01, 8'h08, WG, 16'h6985);
    pchk(V, 8'h01, 8'h00, '0, 16'h63C3);
    pchk(C, 8'h01, 8'h10, {PG, PN}, 16'h6985);
    w(`PCRI_OFF_PDIS, 32'h00);
  endtask
  task automatic t_add();
    w(`PCRI_OFF_FCFG, 32'h2000_3284);
    w(`PCRI_OFF_RLEN, 32'h2);
    w(`PCRI_OFF_NEWEST, 32'h0);
    w(`PCRI_OFF_RWR, 32'h0000_0001);
    w(`PCRI_OFF_RWR, 32'h0001_0002);
    pcri_term_i.cmd(32'h0100_0032, {8'h05, 120'h0}, 8'h01, st);
    `CHK(st[31:0], 32'h0300_9000)
    for (int i = 0; i < 3; i++) begin
      pcri_term_i.rd(`PCRI_OFF_RESP, q);
      `CHK(q[7:0], RS[23-8*i-:8])
    end
    pcri_term_i.rd(`PCRI_OFF_NEWEST, q);
    `CHK(q[1:0], 2'h1)
    add(8'h40, 8'h01, 16'h6A86);
    add(8'h81, 8'h01, 16'h6A82);
    add(8'h00, 8'h00, 16'h6700);
    w(`PCRI_OFF_FCFG, 32'h2000_3285);
    add(8'h00, 8'h01, 16'h6982);
    w(`PCRI_OFF_FCFG, 32'h200B_3284);
    add(8'h00, 8'h01, 16'h6982);
    pchk(V, 8'h03, 8'h08, WG, 16'h9000);
    add(8'h00, 8'h01, 16'h9000);
    w(`PCRI_OFF_RWR, 32'h0100_00FF);
    w(`PCRI_OFF_RWR, 32'h0101_00FE);
    add(8'h00, 8'h01, 16'h9000);
    add(8'h00, 8'h01, 16'h6A84);
    pcri_term_i.rd(`PCRI_OFF_NEWEST, q);
    `CHK(q[1:0], 2'h3)
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    nv_rstn <= 1'b1;
    t_pins();
    t_retry();
    t_change();
    t_add();
    summarize();
  end
endmodule
